// >>> design/sfbt_pkg.sv
// shared constants for the serial flash command link and status reporting
package sfbt_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 25; // 40 mhz system clock
  localparam int POWERUP_WAIT_MS = 20; // host wait after supply is good
  localparam int POWERUP_CYC = POWERUP_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int MIN_DESELECT_TIME_NS = 250; // least chip select high time
  localparam int MIN_DESELECT_CYC = (MIN_DESELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_SETUP_NS = 250; // select low to first clock edge
  localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_HOLD_NS = 250; // last clock edge to select high
  localparam int CS_HOLD_CYC = (CS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESELECT_TO_BUSY_DELAY_NS = 200; // longest select rise to busy
  localparam int DESELECT_TO_BUSY_CYC = DESELECT_TO_BUSY_DELAY_NS / CLK_PERIOD_NS;
  localparam int TRANSFER_COMPARE_TIME_US = 200; // longest page to buffer op
  localparam int TRANSFER_COMPARE_CYC = TRANSFER_COMPARE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_PROGRAM_TIME_MS = 20; // longest erase plus program
  localparam int ERASE_PROGRAM_CYC = ERASE_PROGRAM_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROGRAM_TIME_MS = 15; // longest program without erase
  localparam int PROGRAM_CYC = PROGRAM_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PAGE_ERASE_TIME_MS = 10; // longest page erase
  localparam int PAGE_ERASE_CYC = PAGE_ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BLOCK_ERASE_TIME_MS = 15; // longest block erase
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // ==========================================================
  // host serial clock divider: 8 system cycles per bit, 5 mhz
  localparam logic [2:0] BIT_PH_FALL = 3'h0; // drive clock low, present data
  localparam logic [2:0] BIT_PH_RISE = 3'h4; // drive clock high, device samples
  localparam logic [2:0] BIT_PH_LAST = 3'h7; // host samples returned bit
  // ==========================================================
  // command frame
  localparam int CMD_BITS = 32; // opcode plus 24 address bits
  localparam int STAT_FRAME_BITS = 16; // opcode plus one status byte
  localparam int PAGE_LSB = 9; // page address position in address field
  localparam int PAGE_W = 9;
  localparam int RSVD_LSB = 18; // reserved address bits, ignored here
  localparam int RSVD_W = 6;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_STATUS_READ = 8'h57;
  localparam logic [7:0] OP_PAGE_TO_BUF = 8'h53;
  localparam logic [7:0] OP_PAGE_COMPARE = 8'h60;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h82;
  localparam logic [7:0] OP_AUTO_REWRITE = 8'h58;
  localparam logic [7:0] OP_PROGRAM_ONLY = 8'h88;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  // ==========================================================
  // status byte layout
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_MISMATCH_BIT = 6;
  localparam int STAT_DENSITY_LSB = 3;
  localparam logic [2:0] DENSITY_CODE = 3'h5; // arbitrary neutral value
  localparam logic [2:0] STAT_UNDEF_VALUE = 3'h0; // undefined low bits
  localparam logic STAT_MISMATCH_RESET = 1'b0;
  localparam logic MODE3_RESET = 1'b1; // default mode after reset
endpackage : sfbt_pkg

// >>> design/sfbt_link_if.sv
// serial flash link between host controller and flash device
`timescale 1ns/1ps
`default_nettype none
interface sfbt_link_if;
  logic cs_n; // chip select, active low
  logic sck; // serial clock from host
  logic si; // serial data host to device
  logic so_o; // device serial data out
  logic so_oe; // device drives serial out
  logic rdy_oe; // device pulls ready line low
  logic reset_n; // device reset pin, active low
  logic so_line; // resolved serial out wire
  logic rdy_line; // resolved ready line, pulled up
  // ==========================================================
  // wire resolution: undriven lines read high through pull-ups
  assign so_line = so_oe ? so_o : 1'b1;
  assign rdy_line = rdy_oe ? 1'b0 : 1'b1;
  modport dev (input cs_n, input sck, input si, input reset_n,
               output so_o, output so_oe, output rdy_oe);
  modport host (output cs_n, output sck, output si, output reset_n,
                input so_line, input rdy_line);
endinterface : sfbt_link_if
`default_nettype wire

// >>> design/sfbt_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sfbt_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff; // first stage, read only by second stage
  logic [W-1:0] q_ff; // second stage
  // ==========================================================
  // two stages, synchronous reset to a constant
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= INIT;
      q_ff <= INIT;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule : sfbt_sync2
`default_nettype wire

// >>> design/sfbt_device.sv
// flash device end: serial command capture, status output, busy timing
`timescale 1ns/1ps
`default_nettype none
module sfbt_device #(
  parameter int XFR_CYC = sfbt_pkg::TRANSFER_COMPARE_CYC,
  parameter int EP_CYC = sfbt_pkg::ERASE_PROGRAM_CYC,
  parameter int P_CYC = sfbt_pkg::PROGRAM_CYC,
  parameter int PE_CYC = sfbt_pkg::PAGE_ERASE_CYC,
  parameter int BE_CYC = sfbt_pkg::BLOCK_ERASE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  sfbt_link_if.dev link,
  output logic array_start,
  output logic [7:0] array_op,
  output logic [sfbt_pkg::PAGE_W-1:0] array_page,
  input wire logic array_mismatch,
  output logic busy,
  output logic mode3
);
  // ==========================================================
  // link domain: clocked by the serial clock, cleared by select high
  logic [5:0] bit_cnt_ff; // bits captured this frame, saturates
  logic [sfbt_pkg::CMD_BITS-1:0] cmd_sh_ff; // command shift register
  logic stat_ff; // status read opcode seen
  logic so_ff; // serial out bit
  logic mode3_ff; // clock level caught at select fall
  logic [sfbt_pkg::CMD_BITS-1:0] cmd_hold_ff; // frame held at select rise
  logic cmd_full_ff; // frame had a full command
  logic [1:0] stat_src; // ready and mismatch into link domain
  logic [1:0] stat_sync; // synchronised in link domain
  logic [7:0] status_byte; // assembled status byte
  logic [7:0] nxt_cmd_sh; // next opcode view after this bit
  logic busy_ff; // self-timed operation running, system domain
  logic mismatch_ff; // last compare result, system domain

  // ==========================================================
  // clock level at select fall picks the mode; reset pin gives mode 3
  always_ff @(negedge link.cs_n or negedge link.reset_n) begin
    if (!link.reset_n) begin
      mode3_ff <= sfbt_pkg::MODE3_RESET;
    end else begin
      mode3_ff <= link.sck;
    end
  end

  // ==========================================================
  // rising edges capture data in either mode; a leading falling edge
  // in mode 3 touches nothing here, so both idle levels work
  assign nxt_cmd_sh = {cmd_sh_ff[6:0], link.si};
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_ff <= 6'h00;
      cmd_sh_ff <= '0;
      stat_ff <= 1'b0;
    end else begin
      cmd_sh_ff <= {cmd_sh_ff[sfbt_pkg::CMD_BITS-2:0], link.si};
      if (bit_cnt_ff != 6'h3f) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01; // saturate on long frames
      end
      if (bit_cnt_ff == 6'h07 && nxt_cmd_sh == sfbt_pkg::OP_STATUS_READ) begin
        stat_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // ready and mismatch levels cross into the link clock
  assign stat_src = {~busy_ff, mismatch_ff};
  sfbt_sync2 #(.W(2), .INIT(2'h2)) u_stat_sync (
    .clk(link.sck),
    .rst(1'b0),
    .d(stat_src),
    .q(stat_sync)
  );
  // status is rebuilt every bit, so each repeat carries fresh data
  assign status_byte = {stat_sync[1], stat_sync[0], sfbt_pkg::DENSITY_CODE,
                        sfbt_pkg::STAT_UNDEF_VALUE};

  // ==========================================================
  // output changes on falling edges; bit index wraps every eight
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      so_ff <= 1'b0;
    end else if (stat_ff) begin
      so_ff <= status_byte[3'h7 - bit_cnt_ff[2:0]];
    end
  end
  assign link.so_o = so_ff;
  assign link.so_oe = ~link.cs_n & stat_ff; // released while deselected

  // ==========================================================
  // frame snapshot at select rise; the counters clear right after,
  // so the clock domain reads this copy, stable while select is high
  always_ff @(posedge link.cs_n or negedge link.reset_n) begin
    if (!link.reset_n) begin
      cmd_hold_ff <= '0;
      cmd_full_ff <= 1'b0;
    end else begin
      cmd_hold_ff <= cmd_sh_ff;
      cmd_full_ff <= (bit_cnt_ff >= 6'(sfbt_pkg::CMD_BITS));
    end
  end

  // ==========================================================
  // system domain: select and reset pin synchronised
  logic [1:0] pin_sync; // {cs_n, reset_n}
  logic cs_prev_ff; // synced select, one cycle back
  logic cs_rise; // select rise seen in system domain
  logic pin_rst; // reset pin low
  logic [19:0] busy_cnt_ff; // remaining busy cycles
  logic [19:0] op_cycles; // duration of launched op
  logic op_known; // opcode is self-timed
  logic cmp_run_ff; // running op is a compare
  logic start_ff; // launch pulse to array
  logic [7:0] op_ff; // launched opcode
  logic [sfbt_pkg::PAGE_W-1:0] page_ff; // launched page
  logic mode3_sync; // mode for user side
  logic [7:0] held_op; // opcode of held frame

  sfbt_sync2 #(.W(2), .INIT(2'h3)) u_pin_sync (
    .clk(clk),
    .rst(sys_rst),
    .d({link.cs_n, link.reset_n}),
    .q(pin_sync)
  );
  sfbt_sync2 #(.W(1), .INIT(sfbt_pkg::MODE3_RESET)) u_mode_sync (
    .clk(clk),
    .rst(sys_rst),
    .d(mode3_ff),
    .q(mode3_sync)
  );
  assign pin_rst = ~pin_sync[0];
  assign cs_rise = pin_sync[1] & ~cs_prev_ff;
  assign held_op = cmd_hold_ff[sfbt_pkg::CMD_BITS-1 -: 8];

  // ==========================================================
  // select edge detector on the synced level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_prev_ff <= 1'b1;
    end else begin
      cs_prev_ff <= pin_sync[1];
    end
  end

  // ==========================================================
  // busy duration per opcode; unknown opcodes launch nothing
  always_comb begin
    op_known = 1'b1;
    op_cycles = 20'h00000;
    unique case (held_op)
      sfbt_pkg::OP_PAGE_TO_BUF: op_cycles = 20'(XFR_CYC);
      sfbt_pkg::OP_PAGE_COMPARE: op_cycles = 20'(XFR_CYC);
      sfbt_pkg::OP_PAGE_PROGRAM: op_cycles = 20'(EP_CYC);
      sfbt_pkg::OP_AUTO_REWRITE: op_cycles = 20'(EP_CYC);
      sfbt_pkg::OP_PROGRAM_ONLY: op_cycles = 20'(P_CYC);
      sfbt_pkg::OP_PAGE_ERASE: op_cycles = 20'(PE_CYC);
      sfbt_pkg::OP_BLOCK_ERASE: op_cycles = 20'(BE_CYC);
      default: op_known = 1'b0;
    endcase
  end

  // ==========================================================
  // busy timer; a launch while busy is dropped, host must poll first
  always_ff @(posedge clk) begin
    if (sys_rst || pin_rst) begin
      busy_ff <= 1'b0;
      busy_cnt_ff <= 20'h00000;
      cmp_run_ff <= 1'b0;
    end else if (!busy_ff) begin
      if (cs_rise && cmd_full_ff && op_known) begin
        busy_ff <= 1'b1;
        busy_cnt_ff <= op_cycles - 20'h00001;
        cmp_run_ff <= (held_op == sfbt_pkg::OP_PAGE_COMPARE);
      end
    end else if (busy_cnt_ff == 20'h00000) begin
      busy_ff <= 1'b0;
      cmp_run_ff <= 1'b0;
    end else begin
      busy_cnt_ff <= busy_cnt_ff - 20'h00001;
    end
  end

  // ==========================================================
  // array launch pulse; reserved address bits are not looked at
  always_ff @(posedge clk) begin
    if (sys_rst || pin_rst) begin
      start_ff <= 1'b0;
      op_ff <= 8'h00;
      page_ff <= '0;
    end else begin
      start_ff <= ~busy_ff & cs_rise & cmd_full_ff & op_known;
      if (~busy_ff & cs_rise & cmd_full_ff & op_known) begin
        op_ff <= held_op;
        page_ff <= cmd_hold_ff[sfbt_pkg::PAGE_LSB +: sfbt_pkg::PAGE_W];
      end
    end
  end

  // ==========================================================
  // compare result taken as the compare finishes
  always_ff @(posedge clk) begin
    if (sys_rst || pin_rst) begin
      mismatch_ff <= sfbt_pkg::STAT_MISMATCH_RESET;
    end else if (cmp_run_ff && busy_cnt_ff == 20'h00000) begin
      mismatch_ff <= array_mismatch;
    end
  end

  assign link.rdy_oe = busy_ff;
  assign busy = busy_ff;
  assign array_start = start_ff;
  assign array_op = op_ff;
  assign array_page = page_ff;
  assign mode3 = mode3_sync;
endmodule : sfbt_device
`default_nettype wire

// >>> design/sfbt_host.sv
// host end: spi command master with power-up wait and ready polling
`timescale 1ns/1ps
`default_nettype none
module sfbt_host #(
  parameter int PWRUP_CYC = sfbt_pkg::POWERUP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  sfbt_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [23:0] cmd_addr,
  input wire logic cmd_mode3,
  output logic status_valid,
  output logic [7:0] status_data
);
  typedef enum {ST_PWRUP, ST_IDLE, ST_SETUP, ST_SHIFT, ST_HOLD, ST_DESEL,
                ST_WAIT_RDY} sfbt_hstate_t;
  sfbt_hstate_t state_ff; // sequencer state
  logic [19:0] wait_ff; // general wait counter
  logic [2:0] ph_ff; // phase within one bit
  logic [5:0] bits_ff; // bits left in frame
  logic [31:0] tx_ff; // outgoing frame
  logic [7:0] rx_ff; // returned bits
  logic stat_cmd_ff; // frame is a status read
  logic mode3_ff; // idle clock level of frame
  logic cs_n_ff, sck_ff, si_ff; // pin drivers
  logic st_vld_ff; // status pulse
  logic [7:0] st_data_ff; // last status byte
  logic [1:0] in_sync; // {so, ready}

  sfbt_sync2 #(.W(2), .INIT(2'h3)) u_in_sync (
    .clk(clk),
    .rst(sys_rst),
    .d({link.so_line, link.rdy_line}),
    .q(in_sync)
  );

  // ==========================================================
  // sequencer: power-up wait, frame, hold, deselect, ready poll
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= ST_PWRUP;
      wait_ff <= 20'(PWRUP_CYC);
      ph_ff <= 3'h0;
      bits_ff <= 6'h00;
      tx_ff <= 32'h00000000;
      rx_ff <= 8'h00;
      stat_cmd_ff <= 1'b0;
      mode3_ff <= sfbt_pkg::MODE3_RESET;
      cs_n_ff <= 1'b1;
      sck_ff <= sfbt_pkg::MODE3_RESET;
      si_ff <= 1'b0;
      st_vld_ff <= 1'b0;
      st_data_ff <= 8'h00;
    end else begin
      st_vld_ff <= 1'b0;
      unique case (state_ff)
        ST_PWRUP: begin
          if (wait_ff == 20'h00000) begin
            state_ff <= ST_IDLE;
          end else begin
            wait_ff <= wait_ff - 20'h00001;
          end
        end
        ST_IDLE: begin
          sck_ff <= cmd_mode3;
          if (cmd_valid) begin
            mode3_ff <= cmd_mode3;
            stat_cmd_ff <= (cmd_opcode == sfbt_pkg::OP_STATUS_READ);
            tx_ff <= {cmd_opcode, 6'h00, cmd_addr[17:0]};
            bits_ff <= (cmd_opcode == sfbt_pkg::OP_STATUS_READ) ?
                       6'(sfbt_pkg::STAT_FRAME_BITS) : 6'(sfbt_pkg::CMD_BITS);
            wait_ff <= 20'(sfbt_pkg::CS_SETUP_CYC);
            ph_ff <= 3'h0;
            state_ff <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // select falls one cycle after the idle level is set, so the
          // device never sees clock and select move on the same edge
          cs_n_ff <= 1'b0;
          if (wait_ff == 20'h00000) begin
            state_ff <= ST_SHIFT;
          end else begin
            wait_ff <= wait_ff - 20'h00001;
          end
        end
        ST_SHIFT: begin
          ph_ff <= ph_ff + 3'h1;
          if (ph_ff == sfbt_pkg::BIT_PH_FALL) begin
            sck_ff <= 1'b0; // data changes while clock low
            si_ff <= tx_ff[31];
          end else if (ph_ff == sfbt_pkg::BIT_PH_RISE) begin
            sck_ff <= 1'b1; // device captures here
          end else if (ph_ff == sfbt_pkg::BIT_PH_LAST) begin
            rx_ff <= {rx_ff[6:0], in_sync[1]};
            tx_ff <= {tx_ff[30:0], 1'b0};
            bits_ff <= bits_ff - 6'h01;
            if (bits_ff == 6'h01) begin
              wait_ff <= 20'(sfbt_pkg::CS_HOLD_CYC);
              state_ff <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          sck_ff <= mode3_ff; // back to the idle level
          if (wait_ff == 20'h00000) begin
            cs_n_ff <= 1'b1;
            wait_ff <= 20'(sfbt_pkg::MIN_DESELECT_CYC);
            state_ff <= ST_DESEL;
            if (stat_cmd_ff) begin
              st_vld_ff <= 1'b1;
              st_data_ff <= rx_ff;
            end
          end else begin
            wait_ff <= wait_ff - 20'h00001;
          end
        end
        ST_DESEL: begin
          if (wait_ff == 20'h00000) begin
            state_ff <= stat_cmd_ff ? ST_IDLE : ST_WAIT_RDY;
          end else begin
            wait_ff <= wait_ff - 20'h00001;
          end
        end
        ST_WAIT_RDY: begin
          if (in_sync[0]) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign cmd_ready = (state_ff == ST_IDLE);
  assign link.cs_n = cs_n_ff;
  assign link.sck = sck_ff;
  assign link.si = si_ff;
  assign link.reset_n = ~sys_rst;
  assign status_valid = st_vld_ff;
  assign status_data = st_data_ff;
endmodule : sfbt_host
`default_nettype wire

// >>> bench/sfbt_link_props.sv
// checker watching the serial flash link between host and device
`timescale 1ns/1ps
`default_nettype none
module sfbt_link_props #(
  parameter int MAX_BUSY = 80,
  parameter int PWRUP = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_line,
  input wire logic so_oe,
  input wire logic rdy_oe
);
  // ==========================================================
  // frame tracking helpers
  logic sck_ff; // serial clock one cycle ago
  logic [5:0] cnt_ff; // rising clocks seen in this frame
  logic [7:0] op_ff; // opcode shifted in
  logic [31:0] busy_ff; // cycles the ready line has been held low
  logic [31:0] up_ff; // cycles since reset
  logic rise; // serial clock rose while selected
  logic launch; // frame long enough to start a timed op
  assign rise = sck & ~sck_ff & ~cs_n;
  assign launch = (cnt_ff >= 6'd32) && (op_ff != sfbt_pkg::OP_STATUS_READ);
  // edge detect on the serial clock
  always_ff @(posedge clk) begin
    sck_ff <= sck;
  end
  // count clocks, cleared while deselected; saturates so long frames cannot wrap
  always_ff @(posedge clk) begin
    if (sys_rst || cs_n) begin
      cnt_ff <= 6'h0;
    end else if (rise && cnt_ff != 6'h3f) begin
      cnt_ff <= cnt_ff + 6'h1;
    end
  end
  // opcode is the first eight bits, kept after select rises
  always_ff @(posedge clk) begin
    if (rise && cnt_ff < 6'd8) begin
      op_ff <= {op_ff[6:0], si};
    end
  end
  // length of the current busy stretch
  always_ff @(posedge clk) begin
    if (sys_rst || !rdy_oe) begin
      busy_ff <= 32'h0;
    end else begin
      busy_ff <= busy_ff + 32'h1;
    end
  end
  // time since reset, for the power-up wait
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      up_ff <= 32'h0;
    end else if (up_ff != 32'hffffffff) begin
      up_ff <= up_ff + 32'h1;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_hold_high;
    cs_n [*8] ##1 cs_n [*2];
  endsequence
  sequence s_busy_soon;
    ##[1:8] rdy_oe;
  endsequence
  property p_busy_quick;
    $rose(cs_n) && launch |-> s_busy_soon;
  endproperty
  a_busy_quick: assert property (p_busy_quick) else $error("ready line late to fall");
  property p_busy_bounded;
    rdy_oe |-> busy_ff < MAX_BUSY;
  endproperty
  a_busy_bounded: assert property (p_busy_bounded) else $error("busy too long");
  property p_so_quiet;
    cs_n |-> !so_oe;
  endproperty
  a_so_quiet: assert property (p_so_quiet) else $error("serial out driven while idle");
  property p_density;
    rise && op_ff == sfbt_pkg::OP_STATUS_READ && cnt_ff >= 6'd8 && cnt_ff[2:0] inside {3'h2,
      3'h3, 3'h4} |-> so_line == sfbt_pkg::DENSITY_CODE[3'h4 - cnt_ff[2:0]];
  endproperty
  a_density: assert property (p_density) else $error("density bit wrong");
  property p_deselect;
    $rose(cs_n) |-> s_hold_high;
  endproperty
  a_deselect: assert property (p_deselect) else $error("select high too short");
  property p_setup_idle;
    $fell(cs_n) |-> $stable(sck) [*8];
  endproperty
  a_setup_idle: assert property (p_setup_idle) else $error("clock moved during setup");
  property p_reserved;
    rise && op_ff != sfbt_pkg::OP_STATUS_READ && cnt_ff >= 6'd8 && cnt_ff < 6'd14 |-> !si;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit not zero");
  property p_powerup;
    !cs_n |-> up_ff >= PWRUP;
  endproperty
  a_powerup: assert property (p_powerup) else $error("command before power-up wait");
endmodule : sfbt_link_props
`default_nettype wire

// >>> bench/serial_flash_bus_timing_status_tb.sv
// testbench joining host and device ends across the link
`timescale 1ns/1ps
`default_nettype none
module serial_flash_bus_timing_status_tb;
  // shortened busy and power-up counts
  localparam int XFR = 40;
  localparam int EP = 60;
  localparam int PG = 70;
  localparam int PE = 50;
  localparam int BE = 80;
  localparam int PW = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_opcode = 8'h0;
  logic [23:0] cmd_addr = 24'h0;
  logic cmd_mode3 = 1'b1;
  logic array_mismatch = 1'b0;
  logic cmd_ready, status_valid, array_start, busy, mode3;
  logic [7:0] status_data, array_op, seen_op, last_stat;
  logic [8:0] array_page, seen_page;
  int err_total = 0;
  int n_tests = 0;
  int busy_len, starts;
  always #12.5 clk = ~clk;
  sfbt_link_if sfbt_link_if_inst ();
  sfbt_host #(.PWRUP_CYC(PW)) sfbt_host_inst (.clk(clk), .sys_rst(sys_rst),
    .link(sfbt_link_if_inst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_mode3(cmd_mode3),
    .status_valid(status_valid), .status_data(status_data));
  sfbt_device #(.XFR_CYC(XFR), .EP_CYC(EP), .P_CYC(PG), .PE_CYC(PE), .BE_CYC(BE))
    sfbt_device_inst (.clk(clk), .sys_rst(sys_rst), .link(sfbt_link_if_inst),
    .array_start(array_start), .array_op(array_op), .array_page(array_page),
    .array_mismatch(array_mismatch), .busy(busy), .mode3(mode3));
  sfbt_link_props #(.MAX_BUSY(BE), .PWRUP(PW)) sfbt_link_props_inst (.clk(clk),
    .sys_rst(sys_rst), .cs_n(sfbt_link_if_inst.cs_n), .sck(sfbt_link_if_inst.sck),
    .si(sfbt_link_if_inst.si), .so_line(sfbt_link_if_inst.so_line),
    .so_oe(sfbt_link_if_inst.so_oe), .rdy_oe(sfbt_link_if_inst.rdy_oe));
  // ==========================================================
  // monitor: busy length, launches and last status byte
  always @(posedge clk) begin
    if (busy === 1'b1) busy_len++;
    if (array_start === 1'b1) begin
      starts++;
      seen_op = array_op;
      seen_page = array_page;
    end
    if (status_valid === 1'b1) last_stat = status_data;
  end
  task automatic tally_and_finish;
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // bounded wait for the host to go idle; covers busy and deselect
  task automatic wait_ready;
    int n;
    for (n = 0; n < 4000 && cmd_ready !== 1'b1; n++) @(negedge clk);
    if (n == 4000) begin
      err_total++;
      $display("Error cmd_ready expected 1 seen %b", cmd_ready);
      tally_and_finish();
    end
  endtask : wait_ready
  // one command, held until the host takes it
  task automatic run(input logic [7:0] op, input logic [23:0] addr, input logic m3);
    wait_ready();
    busy_len = 0;
    starts = 0;
    last_stat = 8'hxx;
    cmd_opcode = op;
    cmd_addr = addr;
    cmd_mode3 = m3;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_ready();
  endtask : run
  task automatic t_status;
    run(sfbt_package_status(), 24'h0, 1'b1);
    chk("ready bit", 1, last_stat[7]);
    chk("density", sfbt_pkg::DENSITY_CODE, last_stat[5:3]);
    run(sfbt_package_status(), 24'h0, 1'b0);
    chk("mode after idle low", 0, mode3);
    chk("status in mode 0", {2'b10, sfbt_pkg::DENSITY_CODE}, last_stat[7:3]);
    run(sfbt_package_status(), 24'h0, 1'b1);
    chk("mode after idle high", 1, mode3);
  endtask : t_status
  function automatic logic [7:0] sfbt_package_status();
    return sfbt_pkg::OP_STATUS_READ;
  endfunction : sfbt_package_status
  // every timed operation, reserved bits set, modes alternating
  task automatic t_ops;
    logic [7:0] ops [7] = '{sfbt_pkg::OP_PAGE_TO_BUF, sfbt_pkg::OP_PAGE_COMPARE,
      sfbt_pkg::OP_PAGE_PROGRAM, sfbt_pkg::OP_AUTO_REWRITE, sfbt_pkg::OP_PROGRAM_ONLY,
      sfbt_pkg::OP_PAGE_ERASE, sfbt_pkg::OP_BLOCK_ERASE};
    int lens [7] = '{XFR, XFR, EP, EP, PG, PE, BE};
    logic [8:0] pg;
    for (int i = 0; i < 7; i++) begin
      pg = 9'(i * 37 + 5);
      run(ops[i], {6'h3f, pg, 9'h1ff}, i[0]);
      chk("launches", 1, starts);
      chk("opcode", ops[i], seen_op);
      chk("page", pg, seen_page);
      chk("busy length", 1, busy_len <= lens[i] && busy_len + 2 >= lens[i]);
    end
  endtask : t_ops
  // compare result flag follows the last compare
  task automatic t_compare;
    array_mismatch = 1'b1;
    run(sfbt_pkg::OP_PAGE_COMPARE, 24'h000a00, 1'b0);
    run(sfbt_package_status(), 24'h0, 1'b0);
    chk("mismatch set", 1, last_stat[6]);
    array_mismatch = 1'b0;
    run(sfbt_pkg::OP_PAGE_COMPARE, 24'h000a00, 1'b1);
    run(sfbt_package_status(), 24'h0, 1'b1);
    chk("mismatch clear", 0, last_stat[6]);
  endtask : t_compare
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk("ready during power-up", 0, cmd_ready);
    chk("ready line idle", 1, sfbt_link_if_inst.rdy_line);
    chk("mode after reset", 1, mode3);
    t_status();
    t_ops();
    t_compare();
    tally_and_finish();
  end
endmodule : serial_flash_bus_timing_status_tb
`default_nettype wire
